//--- sdi_defs.vh
`ifndef SDI_DEFS_VH
`define SDI_DEFS_VH
// ----------------------------------------------------------------
// Register map (word indices, byte address bits 5:2)
// ----------------------------------------------------------------
`define SDI_A_GCTL      4'h0
`define SDI_A_STRAP     4'h1
`define SDI_A_MODE      4'h2
`define SDI_A_STATUS    4'h3
`define SDI_A_SYSCFG    4'h4
`define SDI_A_PORTCFG   4'h5
`define SDI_A_BUFCFG    4'h6
`define SDI_A_PHYMAP    4'h7
`define SDI_A_FEBUF     4'h8
`define SDI_A_REGBITS   4
// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define SDI_GCTL_INIT   4
`define SDI_GCTL_BIST   0
`define SDI_GCTL_TORST  1
// ----------------------------------------------------------------
// Strap field positions
// ----------------------------------------------------------------
`define SDI_S_DEBOUNCE  0
`define SDI_S_MODE_LO   1
`define SDI_S_MODE_HI   3
`define SDI_S_ID_LO     4
`define SDI_S_ID_HI     6
`define SDI_S_EEPROM_N  7
`define SDI_S_MODDET    9
`define SDI_S_TORST     12
// ----------------------------------------------------------------
// Host interface modes (strap bits 3:1)
// ----------------------------------------------------------------
`define SDI_M_UNMANAGED 3'h7
`define SDI_M_LT_SSI    3'h3
`define SDI_M_LT_MII    3'h2
`define SDI_M_PAR16     3'h0
`define SDI_M_PAR8      3'h1
`define SDI_HM_UNMGD    3'h0
`define SDI_HM_LTSSI    3'h1
`define SDI_HM_LTMII    3'h2
`define SDI_HM_P16      3'h3
`define SDI_HM_P8       3'h4
`define SDI_HM_RSVD     3'h7
// ----------------------------------------------------------------
// Default configuration values
// ----------------------------------------------------------------
`define SDI_AGE_SEC     16'h012C
`define SDI_FC_FRAMES   8'h60
`define SDI_MIN_FRAME   16'h0040
`define SDI_MAX_FRAME   16'h05F2
`define SDI_FE_POOL     12'h060
`define SDI_FE_THR      12'h030
`define SDI_UP_POOL     12'h180
`define SDI_UP_THR      12'h0C0
`define SDI_HDR_PAD     4'h8
`define SDI_PHY_FE_BASE 5'h08
`define SDI_PHY_UPLINK  5'h10
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SDI_CLK_MHZ     100
`define SDI_TO_SEC      5
`define SDI_INIT_US     100
`endif

//--- sdi_strap_init.v
`timescale 1ns/1ps
`include "sdi_defs.vh"
// Function
// - Capture straps at reset, hold them afterwards
// - Bits 3:1 select unmanaged or lightly managed
// - Bits 3:1 select 16-bit or 8-bit parallel
// - Bit 0 enables serial strobe debounce
// - Bits 6:4 give serial bus identifier
// - Bit 7 low enables serial memory, unmanaged
// - Bit 9 enables module detect, types from straps
// - Bit 12 enables the timeout-reset monitor
// - Flag any machine busy over five seconds
// - Unmanaged applies defaults right after reset
// - Managed modes switch only after init-complete
// - System defaults: port VLAN, drops, aging 300
// - Flow control at 96, priorities lowest, no pools
// - Ports accept 64-1522, pad, strict priority, learn
// - Fast ports RMII, 100M full, pool 96/48
// - Uplink MII, 100M full, pool 384/192
// - Managed: reserved to host, interrupts enabled
// - Managed: host port 100M full, pad 8, no heartbeat
// - Memory self-test at power-up and on request
// - PHY address 0x08+n fast ports, 0x10 uplink
module sdi_strap_init #(
  parameter NPORT      = 8,                              // Fast Ethernet ports
  parameter BIST_CYC   = 256,                            // Self-test length
  parameter TO_CYC     = `SDI_TO_SEC * `SDI_CLK_MHZ * 1000000, // Stuck limit
  parameter INIT_CYC   = `SDI_INIT_US * `SDI_CLK_MHZ     // Table init time
) (
  input  wire             I_CLK,          // Core clock
  input  wire             I_RST,          // Sync reset, active high
  input  wire [15:0]      I_STRAP_BUS,    // Strap bus pins
  input  wire [NPORT-1:0] I_PORT_TX_EN_STRAP, // Per-port tx-enable straps
  input  wire             I_SM_BUSY,      // Any state machine non-idle
  input  wire [31:0]      I_HADDR,        // AHB address
  input  wire [1:0]       I_HTRANS,       // AHB transfer type
  input  wire             I_HWRITE,       // AHB write
  input  wire [2:0]       I_HSIZE,        // AHB size
  input  wire [31:0]      I_HWDATA,       // AHB write data
  input  wire             I_HSEL,         // AHB select
  input  wire             I_HREADY,       // AHB ready in
  output reg  [31:0]      O_HRDATA,       // AHB read data
  output wire             O_HREADYOUT,    // AHB ready out
  output wire             O_HRESP,        // AHB response
  output reg  [2:0]       O_HOST_MODE,    // Decoded host interface mode
  output reg              O_DEBOUNCE_EN,  // Serial strobe debounce on
  output reg  [2:0]       O_DEVICE_ID,    // Serial bus identifier
  output reg              O_EEPROM_LOAD_EN, // Serial memory loading on
  output reg              O_MODULE_DETECT_EN, // Module detect on
  output reg  [NPORT-1:0] O_MODULE_TYPE,  // Per-port module type
  output reg              O_TIMEOUT_EN,   // Timeout monitor on
  output reg              O_TIMEOUT_FLAG, // State machine stuck
  output reg              O_SWITCH_EN,    // Frame switching allowed
  output reg              O_BIST_RUN,     // Memory self-test running
  output reg              O_BIST_DONE,    // Self-test finished once
  output reg              O_TABLES_READY, // Control tables initialised
  output reg              O_MANAGED       // Managed or lightly managed
);

  // ----------------------------------------------------------------
  // Local state
  // ----------------------------------------------------------------
  reg  [15:0]      strap;
  reg  [NPORT-1:0] txen_strap;
  reg              captured;
  reg              init_complete;
  reg              bist_req;
  reg  [31:0]      bist_cnt;
  reg  [31:0]      init_cnt;
  reg  [31:0]      to_cnt;
  reg              dph_valid;
  reg              dph_write;
  reg  [`SDI_A_REGBITS-1:0] dph_idx;
  reg  [2:0]       next_mode;
  reg  [31:0]      rd_mux;
  wire [2:0]       mode_bits = strap[`SDI_S_MODE_HI:`SDI_S_MODE_LO];
  wire             addr_phase = I_HSEL & I_HREADY & I_HTRANS[1];
  wire             gctl_wr = dph_valid & dph_write & (dph_idx == `SDI_A_GCTL);

  // ----------------------------------------------------------------
  // Strap capture
  // ----------------------------------------------------------------
  // Pins are sampled on the first edge after reset release so that no
  // reset path loads a port value; afterwards only a new reset recaptures.
  always @(posedge I_CLK) begin
    if (I_RST) begin
      captured   <= 1'b0;
      strap      <= 16'h0000;
      txen_strap <= {NPORT{1'b0}};
    end else if (!captured) begin
      captured   <= 1'b1;
      strap      <= I_STRAP_BUS;
      txen_strap <= I_PORT_TX_EN_STRAP;
    end
  end

  // Host mode decode from bits 3:1
  always @* begin
    case (mode_bits)
      `SDI_M_UNMANAGED: next_mode = `SDI_HM_UNMGD;
      `SDI_M_LT_SSI:    next_mode = `SDI_HM_LTSSI;
      `SDI_M_LT_MII:    next_mode = `SDI_HM_LTMII;
      `SDI_M_PAR16:     next_mode = `SDI_HM_P16;
      `SDI_M_PAR8:      next_mode = `SDI_HM_P8;
      default:          next_mode = `SDI_HM_RSVD;
    endcase
  end

  // ----------------------------------------------------------------
  // Static configuration outputs
  // ----------------------------------------------------------------
  // Driven only from captured straps; no bus path reaches them.
  always @(posedge I_CLK) begin
    if (I_RST) begin
      O_HOST_MODE        <= `SDI_HM_UNMGD;
      O_DEBOUNCE_EN      <= 1'b0;
      O_DEVICE_ID        <= 3'h0;
      O_EEPROM_LOAD_EN   <= 1'b0;
      O_MODULE_DETECT_EN <= 1'b0;
      O_MODULE_TYPE      <= {NPORT{1'b0}};
      O_TIMEOUT_EN       <= 1'b0;
      O_MANAGED          <= 1'b0;
    end else if (captured) begin
      O_HOST_MODE        <= next_mode;
      O_MANAGED          <= (next_mode != `SDI_HM_UNMGD);
      O_DEBOUNCE_EN      <= strap[`SDI_S_DEBOUNCE];
      O_DEVICE_ID        <= strap[`SDI_S_ID_HI:`SDI_S_ID_LO];
      O_EEPROM_LOAD_EN   <= (next_mode == `SDI_HM_UNMGD) &
                            ~strap[`SDI_S_EEPROM_N];
      O_MODULE_DETECT_EN <= strap[`SDI_S_MODDET];
      O_MODULE_TYPE      <= strap[`SDI_S_MODDET] ? txen_strap
                                                 : {NPORT{1'b0}};
      O_TIMEOUT_EN       <= strap[`SDI_S_TORST];
    end
  end

  // ----------------------------------------------------------------
  // Table init, init-complete and switch gating
  // ----------------------------------------------------------------
  // Host writes before the tables are ready are the host's problem;
  // the ready flag lets software poll instead of timing the wait.
  always @(posedge I_CLK) begin
    if (I_RST) begin
      init_cnt       <= 32'h0000_0000;
      O_TABLES_READY <= 1'b0;
    end else if (!O_TABLES_READY) begin
      if (init_cnt >= INIT_CYC - 1)
        O_TABLES_READY <= 1'b1;
      else
        init_cnt <= init_cnt + 32'h0000_0001;
    end
  end

  always @(posedge I_CLK) begin
    if (I_RST) begin
      init_complete <= 1'b0;
      O_SWITCH_EN   <= 1'b0;
    end else begin
      if (gctl_wr)
        init_complete <= I_HWDATA[`SDI_GCTL_INIT];
      // Unmanaged switches at once; others wait for init-complete
      if (captured)
        O_SWITCH_EN <= (next_mode == `SDI_HM_UNMGD) ? 1'b1
                                                    : init_complete;
    end
  end

  // ----------------------------------------------------------------
  // Memory self-test
  // ----------------------------------------------------------------
  // Power-up run starts from reset; a control write with bit 0 set restarts it.
  always @(posedge I_CLK) begin
    if (I_RST) begin
      O_BIST_RUN  <= 1'b1;
      O_BIST_DONE <= 1'b0;
      bist_cnt    <= 32'h0000_0000;
      bist_req    <= 1'b0;
    end else begin
      bist_req <= gctl_wr & I_HWDATA[`SDI_GCTL_BIST];
      if (bist_req) begin
        O_BIST_RUN <= 1'b1;
        bist_cnt   <= 32'h0000_0000;
      end else if (O_BIST_RUN) begin
        if (bist_cnt >= BIST_CYC - 1) begin
          O_BIST_RUN  <= 1'b0;
          O_BIST_DONE <= 1'b1;
        end else begin
          bist_cnt <= bist_cnt + 32'h0000_0001;
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Timeout monitor
  // ----------------------------------------------------------------
  // Flag is sticky; software clears it, but a new hit in the same
  // cycle wins so the event is never lost.
  always @(posedge I_CLK) begin
    if (I_RST) begin
      to_cnt         <= 32'h0000_0000;
      O_TIMEOUT_FLAG <= 1'b0;
    end else begin
      if (O_TIMEOUT_EN && I_SM_BUSY) begin
        if (to_cnt < TO_CYC)
          to_cnt <= to_cnt + 32'h0000_0001;
      end else begin
        to_cnt <= 32'h0000_0000;
      end
      if (O_TIMEOUT_EN && I_SM_BUSY && to_cnt >= TO_CYC - 1)
        O_TIMEOUT_FLAG <= 1'b1;
      else if (gctl_wr && I_HWDATA[`SDI_GCTL_TORST])
        O_TIMEOUT_FLAG <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // AHB-Lite slave
  // ----------------------------------------------------------------
  // Zero wait states; unmapped words read zero and ignore writes.
  always @(posedge I_CLK) begin
    if (I_RST) begin
      dph_valid <= 1'b0;
      dph_write <= 1'b0;
      dph_idx   <= {`SDI_A_REGBITS{1'b0}};
    end else if (I_HREADY) begin
      dph_valid <= addr_phase & (I_HADDR[31:6] == 26'h0);
      dph_write <= I_HWRITE;
      dph_idx   <= I_HADDR[5:2];
    end
  end

  assign O_HREADYOUT = 1'b1;
  assign O_HRESP     = 1'b0;

  // Read mux of default configuration and status
  always @* begin
    case (I_HADDR[5:2])
      `SDI_A_GCTL:    rd_mux = {27'h0, init_complete, 4'h0};
      `SDI_A_STRAP:   rd_mux = {{(16-NPORT){1'b0}}, txen_strap, strap};
      `SDI_A_MODE:    rd_mux = {24'h0, O_MANAGED, O_HOST_MODE, O_DEVICE_ID,
                                O_DEBOUNCE_EN};
      `SDI_A_STATUS:  rd_mux = {26'h0, O_TABLES_READY, O_SWITCH_EN,
                                O_TIMEOUT_FLAG, O_TIMEOUT_EN, O_BIST_DONE,
                                O_BIST_RUN};
      // Aging 300 s, flow control after 96 frames; other system
      // features (IP multicast, trunk, mirror, WRED, pools) read zero
      `SDI_A_SYSCFG:  rd_mux = {`SDI_AGE_SEC, `SDI_FC_FRAMES,
                                7'h00, O_MANAGED};
      // Max 1522, min 64 frame size
      `SDI_A_PORTCFG: rd_mux = {`SDI_MAX_FRAME, `SDI_MIN_FRAME};
      // Uplink pool and threshold, host port header padding
      `SDI_A_BUFCFG:  rd_mux = {4'h0, `SDI_UP_POOL, `SDI_UP_THR,
                                `SDI_HDR_PAD};
      // Fast and host port pool and threshold share one setting
      `SDI_A_FEBUF:   rd_mux = {8'h00, `SDI_FE_POOL,
                                `SDI_FE_THR};
      // Fast port PHY base and uplink PHY address
      `SDI_A_PHYMAP:  rd_mux = {19'h0, `SDI_PHY_UPLINK, 3'h0,
                                `SDI_PHY_FE_BASE};
      default:        rd_mux = 32'h0000_0000;
    endcase
  end

  // Read data registered into the data phase
  always @(posedge I_CLK) begin
    if (I_RST)
      O_HRDATA <= 32'h0000_0000;
    else if (I_HREADY)
      O_HRDATA <= (addr_phase && !I_HWRITE && I_HADDR[31:6] == 26'h0)
                  ? rd_mux : 32'h0000_0000;
  end

endmodule // sdi_strap_init

//--- sdi_strap_init_chk.sv
`timescale 1ns/1ps
`include "sdi_defs.vh"
module sdi_chk #(
  parameter NPORT  = 8,  // Fast ports
  parameter TO_CYC = 20  // Stuck limit
) (
  input wire             I_CLK,              // Core clock
  input wire             I_RST,              // Sync reset
  input wire             I_SM_BUSY,          // Machine busy
  input wire [2:0]       O_HOST_MODE,        // Host mode
  input wire             O_DEBOUNCE_EN,      // Debounce
  input wire [2:0]       O_DEVICE_ID,        // Bus id
  input wire             O_EEPROM_LOAD_EN,   // Memory load
  input wire             O_MODULE_DETECT_EN, // Detect on
  input wire [NPORT-1:0] O_MODULE_TYPE,      // Types
  input wire             O_TIMEOUT_EN,       // Monitor on
  input wire             O_TIMEOUT_FLAG,     // Stuck flag
  input wire             O_SWITCH_EN,        // Switching
  input wire             O_BIST_RUN,         // Test busy
  input wire             O_BIST_DONE,        // Test done
  input wire             O_MANAGED           // Managed
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (I_RST);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Settled waits until the captured straps have reached the outputs
  reg  [1:0]  up_cnt;
  reg  [31:0] busy_cnt;
  wire        settled = (up_cnt == 2'h3);
  always @(posedge I_CLK) begin
    up_cnt   <= I_RST ? 2'h0 : (settled ? up_cnt : up_cnt + 2'h1);
    busy_cnt <= (I_RST || !I_SM_BUSY) ? 32'h0 : busy_cnt + 32'h1;
  end
  // Properties; the busy counter only ever overcounts, so the bound is safe
  AST_STRAP_HOLD: assert property (
    settled |-> $stable({O_HOST_MODE, O_DEVICE_ID, O_DEBOUNCE_EN, O_EEPROM_LOAD_EN,
                         O_MODULE_DETECT_EN, O_MODULE_TYPE, O_TIMEOUT_EN, O_MANAGED}))
    else $error("strap setting moved");
  AST_UNMGD_RUNS: assert property (
    settled && O_HOST_MODE == `SDI_HM_UNMGD |-> !O_MANAGED && O_SWITCH_EN)
    else $error("unmanaged mode not switching");
  AST_PAR_MANAGED: assert property (
    settled && (O_HOST_MODE == `SDI_HM_P16 || O_HOST_MODE == `SDI_HM_P8) |-> O_MANAGED)
    else $error("parallel mode not managed");
  AST_EEPROM_UNMGD: assert property (
    O_EEPROM_LOAD_EN |-> O_HOST_MODE == `SDI_HM_UNMGD)
    else $error("memory load outside unmanaged");
  AST_TYPE_GATED: assert property (
    !O_MODULE_DETECT_EN |-> O_MODULE_TYPE == {NPORT{1'b0}})
    else $error("module type without detect");
  AST_FLAG_ARMED: assert property (
    O_TIMEOUT_FLAG |-> O_TIMEOUT_EN)
    else $error("flag with monitor off");
  AST_FLAG_LATE: assert property (
    $rose(O_TIMEOUT_FLAG) |-> busy_cnt >= TO_CYC - 1)
    else $error("flag before limit");
  AST_BIST_SPAN: assert property (
    $rose(O_BIST_RUN) |-> O_BIST_RUN[*4] ##[1:600] !O_BIST_RUN)
    else $error("self-test short or stuck");
  AST_BIST_DONE: assert property (
    $fell(O_BIST_RUN) |-> ##[0:1] O_BIST_DONE)
    else $error("self-test end without done");
endmodule // sdi_chk
bind sdi_strap_init sdi_chk #(.NPORT(NPORT), .TO_CYC(TO_CYC)) i_chk (
  .I_CLK, .I_RST, .I_SM_BUSY, .O_HOST_MODE, .O_DEBOUNCE_EN, .O_DEVICE_ID,
  .O_EEPROM_LOAD_EN, .O_MODULE_DETECT_EN, .O_MODULE_TYPE, .O_TIMEOUT_EN,
  .O_TIMEOUT_FLAG, .O_SWITCH_EN, .O_BIST_RUN, .O_BIST_DONE, .O_MANAGED);

//--- sdi_strap_pull.sv
`timescale 1ns/1ps
module sdi_strap_pull (
  input  wire [15:0] i_pull,                // Resistor pattern
  input  wire [7:0]  i_tx_pull,             // Tx-enable pattern
  output wire [15:0] o_strap_bus,           // Strap pins
  output wire [7:0]  o_port_tx_enable_strap // Per-port straps
);
  // Resistors hold a level at all times, so pins never float
  assign o_strap_bus            = i_pull;
  assign o_port_tx_enable_strap = i_tx_pull;
endmodule // sdi_strap_pull

//--- tb_sdi_strap_init.sv
`timescale 1ns/1ps
module tb_sdi_strap_init;
  localparam TO_CYC = 20;  // Short stuck limit keeps the run brief
  logic        clk     = 1'b0;
  logic        rst     = 1'b1;
  logic        sm_busy = 1'b0;
  logic        hwrite  = 1'b0;
  logic [1:0]  htrans  = 2'h0;
  logic [31:0] haddr   = 32'h0;
  logic [31:0] hwdata  = 32'h0;
  logic [31:0] rd;
  logic [15:0] pull    = 16'hFFFF;
  logic [7:0]  tx_pull = 8'hA5;
  wire  [15:0] strap;
  wire  [7:0]  tx_strap, mtype;
  wire  [31:0] hrdata;
  wire  [2:0]  mode, dev_id;
  wire         hready, hresp, deb, eep, mdet, to_en, to_flag, sw_en, b_run, b_done, t_rdy, mgd;
  int          n_fail      = 0;
  int          checks_done = 0;
  // Clock and instances
  always #5 clk = ~clk;
  sdi_strap_pull i_pull (.i_pull(pull), .i_tx_pull(tx_pull), .o_strap_bus(strap),
                         .o_port_tx_enable_strap(tx_strap));
  sdi_strap_init #(.BIST_CYC(8), .TO_CYC(TO_CYC), .INIT_CYC(4)) i_dut (
    .I_CLK(clk), .I_RST(rst), .I_STRAP_BUS(strap), .I_PORT_TX_EN_STRAP(tx_strap),
    .I_SM_BUSY(sm_busy), .I_HADDR(haddr), .I_HTRANS(htrans), .I_HWRITE(hwrite),
    .I_HSIZE(3'h2), .I_HWDATA(hwdata), .I_HSEL(1'b1), .I_HREADY(hready),
    .O_HRDATA(hrdata), .O_HREADYOUT(hready), .O_HRESP(hresp), .O_HOST_MODE(mode),
    .O_DEBOUNCE_EN(deb), .O_DEVICE_ID(dev_id), .O_EEPROM_LOAD_EN(eep),
    .O_MODULE_DETECT_EN(mdet), .O_MODULE_TYPE(mtype), .O_TIMEOUT_EN(to_en),
    .O_TIMEOUT_FLAG(to_flag), .O_SWITCH_EN(sw_en), .O_BIST_RUN(b_run),
    .O_BIST_DONE(b_done), .O_TABLES_READY(t_rdy), .O_MANAGED(mgd));
  // Verdict and stop
  task automatic test_done;
    $display("checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // Ran out of patience waiting on the design
  task automatic give_up;
    n_fail++;
    $display("CHECK FAILED at %0t: wait ran out", $time);
    test_done;
  endtask
  // Single compare, four-state exact
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // Wait for ready at an edge, bounded so a dead slave cannot hang us
  task automatic wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hready !== 1'b1 && n < 20);
    if (hready !== 1'b1) give_up;
  endtask
  // One word transfer; entered just after a rising edge
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr  <= a;
    hwrite <= wr;
    wait_rdy;
    htrans <= 2'h0;
    hwdata <= d;
    wait_rdy;
    rd = hrdata;
    chk(hresp, 1'b0, "bus response");
  endtask
  // Reset with a strap pattern; returns once decoded outputs are settled
  task automatic boot(input logic [15:0] p);
    pull <= p;
    rst  <= 1'b1;
    repeat (2) @(posedge clk);
    rst  <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  // Every mode code, side straps varied so each takes both levels
  task automatic t_modes;
    logic [15:0] p;
    logic [2:0]  s;
    logic [2:0]  em;
    for (int i = 0; i < 8; i++) begin
      s  = i[2:0];
      p  = {3'h7, s[0], 2'h2, s[1], 1'b1, ~s[0], ~s, s, s[0] ^ s[1]};
      em = (s == 3'h7) ? 3'h0 : (s == 3'h3) ? 3'h1 : (s == 3'h2) ? 3'h2 :
           (s == 3'h0) ? 3'h3 : (s == 3'h1) ? 3'h4 : 3'h7;
      boot(p);
      chk({mode, deb, dev_id, eep, mdet, mtype, to_en, sw_en},
          {em, p[0], ~s, s == 3'h7 && !p[7], p[9], p[9] ? tx_pull : 8'h0, p[12], s == 3'h7},
          "strap decode");
      if (s < 3'h4 || s == 3'h7) chk(mgd, s != 3'h7, "managed flag");
    end
  endtask
  // Straps move and host writes after capture; then a stuck machine
  task automatic t_hold;
    int n;
    boot(16'hF11F);
    pull    <= 16'h0000;
    tx_pull <= 8'h3C;
    ahb(1'b1, 32'h4, 32'hFFFFFFFF);
    ahb(1'b0, 32'h4, 32'h0);
    chk(rd, {8'h0, 8'hA5, 16'hF11F}, "captured straps");
    ahb(1'b0, 32'h8, 32'h0);
    chk(rd, {24'h0, 1'b0, 3'h0, 3'h1, 1'b1}, "decoded mode");
    sm_busy <= 1'b1;
    repeat (TO_CYC - 2) @(posedge clk);
    chk(to_flag, 1'b0, "flag too early");
    for (n = 0; n < 10 && to_flag !== 1'b1; n++) @(posedge clk);
    if (n == 10) give_up;
    sm_busy <= 1'b0;
    ahb(1'b1, 32'h0, 32'h2);
    @(posedge clk);
    chk(to_flag, 1'b0, "flag cleared");
  endtask
  // Managed start: defaults, init gate, requested self-test
  task automatic t_managed;
    int n;
    boot(16'hE1F1);
    chk(sw_en, 1'b0, "no switching before init");
    for (n = 0; n < 50 && (t_rdy & b_done) !== 1'b1; n++) @(posedge clk);
    if (n == 50) give_up;
    ahb(1'b0, 32'h10, 32'h0);
    chk({rd[31:8], rd[0]}, {24'h012C60, 1'b1}, "system defaults");
    ahb(1'b0, 32'h14, 32'h0);
    chk(rd, 32'h05F20040, "frame limits");
    ahb(1'b0, 32'h18, 32'h0);
    chk(rd, 32'h01800C08, "buffer pools");
    ahb(1'b0, 32'h1C, 32'h0);
    chk(rd, 32'h00001008, "phy addresses");
    ahb(1'b0, 32'h20, 32'h0);
    chk(rd, 32'h00060030, "fast port pools");
    ahb(1'b0, 32'h24, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    ahb(1'b1, 32'h0, 32'h10);
    repeat (2) @(posedge clk);
    chk(sw_en, 1'b1, "switching after init");
    ahb(1'b1, 32'h0, 32'h11);
    repeat (3) @(posedge clk);
    chk(b_run, 1'b1, "self-test on request");
    for (n = 0; n < 50 && b_run !== 1'b0; n++) @(posedge clk);
    if (n == 50) give_up;
    chk({b_done, sw_en}, 2'h3, "self-test complete");
  endtask
  // Main sequence
  initial begin
    t_modes;
    t_hold;
    t_managed;
    test_done;
  end
endmodule // tb_sdi_strap_init
